// file: hw/uvep_pkg.sv
// Purpose: constants and carrier types for the eprom programmer controller
// Assumes: 25 MHz core_clk
// Notes:   no registers reachable by software
package uvep_pkg;
    localparam int unsigned ADDR_W         = 14;
    localparam int unsigned DATA_W         = 8;
    localparam int unsigned CLK_PERIOD_NS  = 40;
    localparam int unsigned PULSE_MS       = 10;
    localparam int unsigned PULSE_CYCLES   = PULSE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned SETUP_US       = 2;
    localparam int unsigned SETUP_CYCLES   = (SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ACCESS_NS      = 130;
    localparam int unsigned ACCESS_CYCLES  = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MAX_TRIES      = 25;
    localparam int unsigned ID_BIT         = 9;
    localparam int unsigned CODE_BIT       = 0;
    localparam logic [DATA_W-1:0] ERASED   = 8'hFF;

    typedef enum logic [1:0] {UVEP_CMD_READ, UVEP_CMD_PROG, UVEP_CMD_SIG} uvep_cmd_t;

    typedef struct packed {
        uvep_cmd_t          cmd;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  data;
    } uvep_req_t;

    typedef struct packed {
        logic [DATA_W-1:0]  data;
        logic               fail;
    } uvep_rsp_t;

    typedef struct packed {
        logic               ce_n;
        logic               oe_n;
        logic               program_strobe_low;
        logic               vpp_high;
        logic               identification_select_pin;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  dq_out;
        logic               dq_oe;
    } uvep_pins_t;
endpackage

// file: hw/uvep_ctrl.sv
// Purpose: host-side controller driving a byte-wide uv eprom through its pins
// Assumes: device pins on a different timing domain; data bus input synchronised
// Notes:   one request at a time; program uses pulse then verify, with retry

module uvep_ctrl #(
    parameter int unsigned PULSE_CYC = uvep_pkg::PULSE_CYCLES,
    parameter int unsigned MAX_TRY   = uvep_pkg::MAX_TRIES
) (
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    input  wire logic                       req_valid,
    output      logic                       req_ready,
    input  wire uvep_pkg::uvep_req_t        req,
    output      logic                       rsp_valid,
    output      uvep_pkg::uvep_rsp_t        rsp,
    output      uvep_pkg::uvep_pins_t       pins,
    input  wire logic [uvep_pkg::DATA_W-1:0] dq_in
);
    typedef enum logic [3:0] {
        S_IDLE, S_RD_SET, S_RD_WAIT, S_PR_CHECK, S_PR_VPP, S_PR_PULSE, S_PR_HOLD,
        S_VF_SET, S_VF_WAIT, S_VPP_DOWN, S_DONE
    } uvep_state_t;

    typedef struct packed {
        uvep_state_t                state;
        uvep_pkg::uvep_req_t        cur;
        uvep_pkg::uvep_pins_t       pins;
        uvep_pkg::uvep_rsp_t        rsp;
        logic                       rsp_valid;
        logic [23:0]                cnt;
        logic [7:0]                 tries;
        logic [uvep_pkg::DATA_W-1:0] s1;
        logic [uvep_pkg::DATA_W-1:0] s2;
        logic [uvep_pkg::DATA_W-1:0] s3;
        logic [uvep_pkg::DATA_W-1:0] din;
    } uvep_reg_t;

    uvep_reg_t r;
    uvep_reg_t next_r;

    localparam logic [23:0] SETUP_N  = 24'(uvep_pkg::SETUP_CYCLES);
    localparam logic [23:0] ACCESS_N = 24'(uvep_pkg::ACCESS_CYCLES);
    localparam logic [23:0] PULSE_N  = 24'(PULSE_CYC);
    localparam logic [7:0]  TRY_N    = 8'(MAX_TRY);

    assign req_ready = (r.state == S_IDLE);
    assign rsp_valid = r.rsp_valid;
    assign rsp       = r.rsp;
    assign pins      = r.pins;

    always_comb
    begin
        next_r           = r;
        next_r.rsp_valid = 1'b0;
        next_r.s1        = dq_in;
        next_r.s2        = r.s1;
        next_r.s3        = r.s2;
        // data change accepted once second and third stages agree
        if (r.s2 == r.s3)
        begin
            next_r.din = r.s3;
        end
        if (r.cnt != 24'h000000)
        begin
            next_r.cnt = r.cnt - 24'h000001;
        end
        case (r.state)
            S_IDLE:
            begin
                // idle: standby, bus floated by host, strobe high
                next_r.pins.ce_n  = 1'b1;
                next_r.pins.oe_n  = 1'b1;
                next_r.pins.dq_oe = 1'b0;
                if (req_valid)
                begin
                    next_r.cur   = req;
                    next_r.tries = 8'h00;
                    next_r.cnt   = SETUP_N;
                    next_r.pins.addr = req.addr;
                    next_r.pins.identification_select_pin = 1'b0;
                    if (req.cmd == uvep_pkg::UVEP_CMD_SIG)
                    begin
                        next_r.pins.addr = '0;
                        next_r.pins.addr[uvep_pkg::CODE_BIT] = req.addr[uvep_pkg::CODE_BIT];
                        next_r.pins.identification_select_pin = 1'b1;
                    end
                    if (req.cmd == uvep_pkg::UVEP_CMD_PROG)
                    begin
                        next_r.state = S_PR_CHECK;
                        next_r.pins.ce_n = 1'b0;
                        next_r.pins.oe_n = 1'b0;
                    end
                    else
                    begin
                        next_r.state     = S_RD_SET;
                        next_r.pins.ce_n = 1'b0;
                        next_r.pins.oe_n = 1'b0;
                    end
                end
            end
            S_RD_SET:
            begin
                if (r.cnt == 24'h000000)
                begin
                    next_r.cnt   = ACCESS_N + 24'h000004;
                    next_r.state = S_RD_WAIT;
                end
            end
            S_RD_WAIT:
            begin
                if (r.cnt == 24'h000000)
                begin
                    next_r.rsp.data  = r.din;
                    next_r.rsp.fail  = 1'b0;
                    next_r.state     = S_DONE;
                end
            end
            S_PR_CHECK:
            begin
                // pre-read current contents at normal supply
                if (r.cnt == 24'h000000)
                begin
                    if ((r.cur.data & ~r.din) != '0)
                    begin
                        next_r.rsp.data = r.din;
                        next_r.rsp.fail = 1'b1;
                        next_r.state    = S_DONE;
                    end
                    else if (r.din == r.cur.data)
                    begin
                        next_r.rsp.data = r.din;
                        next_r.rsp.fail = 1'b0;
                        next_r.state    = S_DONE;
                    end
                    else
                    begin
                        // strobe high before supply moves
                        next_r.pins.oe_n     = 1'b1;
                        next_r.pins.vpp_high = 1'b1;
                        next_r.pins.dq_out   = r.cur.data;
                        next_r.cnt           = SETUP_N;
                        next_r.state         = S_PR_VPP;
                    end
                end
            end
            S_PR_VPP:
            begin
                next_r.pins.dq_oe = 1'b1;
                if (r.cnt == 24'h000000)
                begin
                    next_r.pins.program_strobe_low = 1'b0;
                    next_r.cnt   = PULSE_N - 24'h000001;
                    next_r.state = S_PR_PULSE;
                end
            end
            S_PR_PULSE:
            begin
                if (r.cnt == 24'h000000)
                begin
                    next_r.pins.program_strobe_low = 1'b1;
                    next_r.tries = r.tries + 8'h01;
                    next_r.cnt   = SETUP_N;
                    next_r.state = S_PR_HOLD;
                end
            end
            S_PR_HOLD:
            begin
                // data hold after pulse, then release bus
                if (r.cnt == 24'h000000)
                begin
                    next_r.pins.dq_oe = 1'b0;
                    next_r.cnt        = SETUP_N;
                    next_r.state      = S_VF_SET;
                end
            end
            S_VF_SET:
            begin
                if (r.cnt == 24'h000000)
                begin
                    next_r.pins.oe_n = 1'b0;
                    next_r.cnt       = ACCESS_N + 24'h000004;
                    next_r.state     = S_VF_WAIT;
                end
            end
            S_VF_WAIT:
            begin
                if (r.cnt == 24'h000000)
                begin
                    if (r.din != r.cur.data && r.tries < TRY_N)
                    begin
                        next_r.pins.oe_n   = 1'b1;
                        next_r.cnt         = SETUP_N;
                        next_r.state       = S_PR_VPP;
                    end
                    else
                    begin
                        next_r.rsp.data    = r.din;
                        next_r.rsp.fail    = (r.din != r.cur.data);
                        next_r.pins.oe_n   = 1'b1;
                        next_r.pins.ce_n   = 1'b1;
                        next_r.cnt         = SETUP_N;
                        next_r.state       = S_VPP_DOWN;
                    end
                end
            end
            S_VPP_DOWN:
            begin
                if (r.cnt == 24'h000000)
                begin
                    next_r.pins.vpp_high = 1'b0;
                    next_r.state         = S_DONE;
                end
            end
            S_DONE:
            begin
                next_r.rsp_valid = 1'b1;
                next_r.pins.ce_n = 1'b1;
                next_r.pins.oe_n = 1'b1;
                next_r.pins.identification_select_pin = 1'b0;
                next_r.state     = S_IDLE;
            end
            default:
            begin
                next_r.state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            r <= '{state: S_IDLE, cur: '0,
                   pins: '{ce_n: 1'b1, oe_n: 1'b1, program_strobe_low: 1'b1, vpp_high: 1'b0,
                           identification_select_pin: 1'b0, addr: '0, dq_out: '0, dq_oe: 1'b0},
                   rsp: '0, rsp_valid: 1'b0, cnt: '0, tries: '0,
                   s1: uvep_pkg::ERASED, s2: uvep_pkg::ERASED, s3: uvep_pkg::ERASED,
                   din: uvep_pkg::ERASED};
        end
        else
        begin
            r <= next_r;
        end
    end

    vpp_stable_a: assert property (@(posedge core_clk) disable iff (rst)
        (!pins.ce_n && !pins.program_strobe_low) |=> $stable(pins.vpp_high))
        else $error("supply switched during strobe");
    ce_low_prog_a: assert property (@(posedge core_clk) disable iff (rst)
        (!pins.program_strobe_low) |-> (pins.vpp_high && !pins.ce_n))
        else $error("pulse without supply or chip enable");
    data_driven_a: assert property (@(posedge core_clk) disable iff (rst)
        (!pins.program_strobe_low) |-> (pins.dq_oe && pins.oe_n && pins.dq_out == r.cur.data))
        else $error("pulse without data driven");
    pulse_len_a: assert property (@(posedge core_clk) disable iff (rst)
        $fell(pins.program_strobe_low) |-> !pins.program_strobe_low [*8])
        else $error("pulse too short");
    no_contention_a: assert property (@(posedge core_clk) disable iff (rst)
        pins.dq_oe |-> pins.oe_n)
        else $error("bus driven while device outputs");
    sig_addr_a: assert property (@(posedge core_clk) disable iff (rst)
        (pins.identification_select_pin && !pins.ce_n) |->
        (pins.addr[uvep_pkg::ADDR_W-1:1] == '0 && !pins.vpp_high))
        else $error("signature address not clean");
    read_levels_a: assert property (@(posedge core_clk) disable iff (rst)
        (r.state == S_RD_WAIT) |-> (!pins.ce_n && !pins.oe_n && !pins.vpp_high))
        else $error("read levels wrong");
    verify_after_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(pins.program_strobe_low) |-> ##[1:300] !pins.oe_n)
        else $error("no verify after pulse");
endmodule

// file: tb/uvep_dev_model.sv
// Purpose: behavioural model of the byte-wide uv eprom behind the controller
// Assumes: pins sampled on core_clk; bus is the resolved data-line level
// Notes:   counts programming pulses and protocol breaches of the controller
module uvep_dev_model #(
    parameter int unsigned PULSE_CYC = 20,
    parameter logic [7:0]  MAKER_ID  = 8'h3C,  // arbitrary value
    parameter logic [7:0]  PART_ID   = 8'h7E   // arbitrary value
) (
    input  wire logic                 core_clk,
    input  wire uvep_pkg::uvep_pins_t pins,
    input  wire logic [7:0]           bus,
    input  wire logic [7:0]           stuck_mask,
    output      logic [7:0]           dq_drv,
    output      logic                 dq_en,
    output      int                   pulses,
    output      int                   viol
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:16383];
    logic [7:0] pend;
    logic       prev_on;
    logic       prev_vpp;
    int         low_len;
    wire logic  prog_on = !pins.ce_n && !pins.program_strobe_low;

    initial
    begin
        for (int i = 0; i < 16384; i++)
            mem[i] = uvep_pkg::ERASED;
        pulses = 0;
        viol = 0;
        low_len = 0;
        prev_on = 1'b0;
        prev_vpp = 1'b0;
    end

    assign dq_en = !pins.oe_n && (pins.vpp_high || !pins.ce_n);

    always_comb
    begin
        if (pins.identification_select_pin && !pins.vpp_high)
            dq_drv = (pins.addr[13:1] == 13'h0000) ? (pins.addr[0] ? PART_ID : MAKER_ID)
                                                   : ~mem[pins.addr];
        else
            dq_drv = mem[pins.addr];
    end

    always @(posedge core_clk)
    begin
        if (prog_on && prev_on && pins.vpp_high !== prev_vpp)
            viol = viol + 1;
        if ((dq_en && pins.dq_oe) || (prog_on && !(pins.vpp_high && pins.oe_n)))
            viol = viol + 1;
        if (prog_on)
        begin
            low_len = low_len + 1;
            pend = bus;
        end
        else if (prev_on)
        begin
            if (low_len != PULSE_CYC)
                viol = viol + 1;
            if (pins.vpp_high)
                mem[pins.addr] = mem[pins.addr] & (pend | stuck_mask);
            pulses = pulses + 1;
            low_len = 0;
        end
        prev_on = prog_on;
        prev_vpp = pins.vpp_high;
    end
endmodule

// file: tb/tb_top.sv
// Purpose: self-checking bench for the eprom programmer controller
// Assumes: short programming pulse and few retries set by parameter
// Notes:   undriven data lines toggle every cycle
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PCYC  = 20;
    localparam int unsigned TRIES = 3;
    localparam logic [7:0]  MK    = 8'h3C;  // arbitrary value
    localparam logic [7:0]  PT    = 8'h7E;  // arbitrary value
    logic                 core_clk;
    logic                 rst;
    logic                 req_valid;
    logic                 req_ready;
    uvep_pkg::uvep_req_t  req;
    logic                 rsp_valid;
    uvep_pkg::uvep_rsp_t  rsp;
    uvep_pkg::uvep_rsp_t  got;
    uvep_pkg::uvep_pins_t pins;
    logic [7:0]           bus;
    logic [7:0]           last = 8'h00;
    logic [7:0]           stuck_mask;
    logic [7:0]           dq_drv;
    logic                 dq_en;
    int                   pulses;
    int                   viol;
    int                   num_errors;
    int                   comparisons;
    int                   p0;

    assign bus = pins.dq_oe ? pins.dq_out : (dq_en ? dq_drv : ~last);
    always @(posedge core_clk) last <= bus;

    uvep_ctrl #(.PULSE_CYC(PCYC), .MAX_TRY(TRIES)) dut (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .dq_in(bus));
    uvep_dev_model #(.PULSE_CYC(PCYC), .MAKER_ID(MK), .PART_ID(PT)) dev (.core_clk(core_clk), .pins(pins),
        .bus(bus), .stuck_mask(stuck_mask), .dq_drv(dq_drv), .dq_en(dq_en), .pulses(pulses), .viol(viol));

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cmp1(input logic g, input logic e);
        cmp8({7'h00, g}, {7'h00, e});
    endtask

    task automatic do_req(input uvep_pkg::uvep_cmd_t c, input logic [13:0] a, input logic [7:0] d);
        int n;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req <= '{cmd: c, addr: a, data: d};
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 5000);
        @(posedge core_clk);
        req_valid <= 1'b0;
        do
        begin
            @(negedge core_clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 5000);
        got = rsp;
        if (n >= 5000)
        begin
            num_errors++;
            close_out();
        end
    endtask

    task automatic t_reset();
        cmp1(pins.ce_n, 1'b1);
        cmp1(pins.vpp_high, 1'b0);
        cmp1(dq_en, 1'b0);
        cmp1(req_ready, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_read_erased();
        do_req(uvep_pkg::UVEP_CMD_READ, 14'h0000, 8'h00);
        cmp8(got.data, uvep_pkg::ERASED);
        do_req(uvep_pkg::UVEP_CMD_READ, 14'h3FFF, 8'h00);
        cmp8(got.data, uvep_pkg::ERASED);
        cmp1(got.fail, 1'b0);
        $display("test read erased done");
    endtask

    task automatic t_program();
        p0 = pulses;
        do_req(uvep_pkg::UVEP_CMD_PROG, 14'h0005, 8'hA5);
        cmp1(got.fail, 1'b0);
        cmp8(8'(pulses - p0), 8'h01);
        cmp1(pins.vpp_high, 1'b0);
        do_req(uvep_pkg::UVEP_CMD_READ, 14'h0005, 8'h00);
        cmp8(got.data, 8'hA5);
        cmp8(8'(viol), 8'h00);
        $display("test program done");
    endtask

    task automatic t_refuse();
        p0 = pulses;
        do_req(uvep_pkg::UVEP_CMD_PROG, 14'h0005, 8'h5A);
        cmp1(got.fail, 1'b1);
        cmp8(got.data, 8'hA5);
        do_req(uvep_pkg::UVEP_CMD_PROG, 14'h0007, 8'hFF);
        cmp1(got.fail, 1'b0);
        cmp8(8'(pulses - p0), 8'h00);
        $display("test refuse done");
    endtask

    task automatic t_signature();
        for (int b = 0; b < 2; b++)
        begin
            do_req(uvep_pkg::UVEP_CMD_SIG, {13'h1555, b[0]}, 8'h00);
            cmp8(got.data, b[0] ? PT : MK);
        end
        $display("test signature done");
    endtask

    task automatic t_stuck();
        p0 = pulses;
        stuck_mask <= 8'h01;
        do_req(uvep_pkg::UVEP_CMD_PROG, 14'h0009, 8'h00);
        cmp1(got.fail, 1'b1);
        cmp8(8'(pulses - p0), 8'(TRIES));
        stuck_mask <= 8'h00;
        do_req(uvep_pkg::UVEP_CMD_READ, 14'h0009, 8'h00);
        cmp8(got.data, 8'h01);
        cmp8(8'(viol), 8'h00);
        $display("test retry done");
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    initial
    begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        stuck_mask = 8'h00;
        num_errors = 0;
        comparisons = 0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        t_reset();
        t_read_erased();
        t_program();
        t_refuse();
        t_signature();
        t_stuck();
        close_out();
    end
endmodule
